// [core/dfr_pkg.sv]
// Functional notes
// (RULE1) take 32 samples per mains cycle; binary traces use the same sample grid
// (RULE2) up to eight enabled trigger inputs are ORed to start a record
// (RULE3) no new record until all triggers that caused the last one deassert
// (RULE4) storage holds a fixed total time shared by all records
// (RULE5) record length limit is configurable up to 15 s, all parts included
// (RULE6) pre and post durations are percentages of the length limit
// (RULE7) each record starts with exactly the pre-capture history
// (RULE8) event part is min(trigger active time, limit minus pre part)
// (RULE9) post part is min(post setting, time left in limit); may be zero
// (RULE10) recording always stops once the length limit has elapsed
// (RULE11) full storage: overwrite oldest if enabled, otherwise refuse until cleared
// (RULE12) manual trigger command starts a record like a trigger input
// (RULE13) authorised delete removes the selected record or all records
// (RULE14) rising edge of general pickup starts a fault record
// (RULE15) measurements latch at trip or after a configurable delay
// (RULE16) alarms-and-trips mode stores pickups without trip; trips-only does not
// (RULE17) fault notification rises when general pickup deasserts
// (RULE18) time to trip runs from first pickup to first trip
// (RULE19) fault duration runs from pickup rise to pickup fall
// (RULE20) general trip is the OR of all trip outputs
// (RULE21) time to trip invalid when first pickup and first trip functions differ
// (RULE22) fault and waveform records carry the same fault and grid numbers
// (RULE23) fault number counts up once per general pickup assertion
// (RULE24) fault store holds 20 records, replacing the oldest first
// (RULE25) samples run continuously through a circular pre-capture history
package dfr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DFR_CLK_HZ = 250_000_000;
  localparam int DFR_MAINS_HZ = 50;
  localparam int DFR_SAMPLES_PER_CYCLE = 32;
  localparam int DFR_SAMPLE_DIV = DFR_CLK_HZ / (DFR_MAINS_HZ * DFR_SAMPLES_PER_CYCLE);
  localparam int DFR_STORE_TIME_S = 120;
  localparam int DFR_LIMIT_MAX_S = 15;
  localparam int DFR_STORE_SAMPLES = DFR_STORE_TIME_S * DFR_MAINS_HZ * DFR_SAMPLES_PER_CYCLE;
  localparam int DFR_LIMIT_MAX = DFR_LIMIT_MAX_S * DFR_MAINS_HZ * DFR_SAMPLES_PER_CYCLE;
  localparam int DFR_PCT_FULL = 100;
  localparam int DFR_N_TRIG = 8;
  localparam int DFR_FAULT_DEPTH = 20;
  localparam int DFR_MEAS_W = 32;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DFR_OFS_CTRL = 8'h00;
  localparam logic [7:0] DFR_OFS_LIMIT = 8'h04;
  localparam logic [7:0] DFR_OFS_PCT = 8'h08;
  localparam logic [7:0] DFR_OFS_MDELAY = 8'h0C;
  localparam logic [7:0] DFR_OFS_CMD = 8'h10;
  localparam logic [7:0] DFR_OFS_STATUS = 8'h14;
  localparam logic [7:0] DFR_OFS_WSEL = 8'h18;
  localparam logic [7:0] DFR_OFS_WSTART = 8'h1C;
  localparam logic [7:0] DFR_OFS_WLEN = 8'h20;
  localparam logic [7:0] DFR_OFS_WFAULT = 8'h24;
  localparam logic [7:0] DFR_OFS_MADDR = 8'h28;
  localparam logic [7:0] DFR_OFS_MDATA = 8'h2C;
  localparam logic [7:0] DFR_OFS_FSEL = 8'h30;
  localparam logic [7:0] DFR_OFS_FNUM = 8'h34;
  localparam logic [7:0] DFR_OFS_FTTT = 8'h38;
  localparam logic [7:0] DFR_OFS_FDUR = 8'h3C;
  localparam logic [7:0] DFR_OFS_FMEAS = 8'h40;
  localparam logic [7:0] DFR_OFS_FINFO = 8'h44;

  // field positions
  localparam int DFR_CTRL_OVWR = 0;
  localparam int DFR_CTRL_ALARMS = 1;
  localparam int DFR_CTRL_TEN_LO = 8;
  localparam int DFR_PCT_POST_LO = 8;
  localparam int DFR_CMD_MANUAL = 0;
  localparam int DFR_CMD_DEL_SEL = 1;
  localparam int DFR_CMD_DEL_ALL = 2;
  localparam int DFR_CMD_KEY_LO = 16;
  localparam int DFR_VALID_BIT = 31;

  // reset values; delete key value is arbitrary
  localparam logic [15:0] DFR_DELETE_KEY = 16'hA5C3;
  localparam logic [31:0] DFR_CTRL_RST = 32'h0000_FF01;
  localparam logic [15:0] DFR_LIMIT_RST = 16'h0640;
  localparam logic [6:0] DFR_PRE_RST = 7'h14;
  localparam logic [6:0] DFR_POST_RST = 7'h14;
  localparam logic [31:0] DFR_MDELAY_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    DFR_W_IDLE = 2'b00,
    DFR_W_EVENT = 2'b01,
    DFR_W_POST = 2'b10
  } dfr_wstate_t;

  typedef struct packed {
    logic [15:0] fault_no;
    logic [15:0] grid_no;
    logic [31:0] ttt;
    logic ttt_valid;
    logic [31:0] dur;
    logic [DFR_MEAS_W-1:0] meas;
    logic [7:0] first_pu;
    logic [7:0] first_tr;
    logic tripped;
  } dfr_fault_rec_t;

endpackage : dfr_pkg

// [core/dfr_recorder.sv]
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module dfr_recorder import dfr_pkg::*; #(
  parameter int SAMPLE_W = 32,
  parameter int N_FUNC = 8,
  parameter int STORE_N = DFR_STORE_SAMPLES,
  parameter int SAMPLE_DIV_P = DFR_SAMPLE_DIV,
  parameter int MAX_RECS = 32,
  parameter int FAULT_DEPTH_P = DFR_FAULT_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic [DFR_N_TRIG-1:0] trig_i,
  input wire logic [N_FUNC-1:0] pickup_i,
  input wire logic [N_FUNC-1:0] trip_i,
  input wire logic [DFR_MEAS_W-1:0] meas_i,
  output logic sample_tick,
  output logic wave_active,
  output logic fault_notify
);

  localparam int PTR_W = $clog2(STORE_N);
  localparam int DIV_W = $clog2(SAMPLE_DIV_P + 1);
  localparam int RI_W = $clog2(MAX_RECS);
  localparam int FI_W = $clog2(FAULT_DEPTH_P + 1);
  localparam int FN_W = $clog2(N_FUNC);
  localparam logic [PTR_W:0] STORE_W = (PTR_W + 1)'(STORE_N);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] a,
                                               input logic [PTR_W:0] b);
    logic [PTR_W+1:0] s;
    s = {2'b00, a} + {1'b0, b};
    if (s >= {1'b0, STORE_W}) s = s - {1'b0, STORE_W};
    return s[PTR_W-1:0];
  endfunction : ptr_add

  function automatic logic [PTR_W:0] ptr_dist(input logic [PTR_W-1:0] from,
                                              input logic [PTR_W-1:0] to);
    logic [PTR_W+1:0] s;
    s = {2'b00, to} + {1'b0, STORE_W} - {2'b00, from};
    if (s >= {1'b0, STORE_W}) s = s - {1'b0, STORE_W};
    return s[PTR_W:0];
  endfunction : ptr_dist

  function automatic logic [15:0] pct_of(input logic [15:0] lim, input logic [6:0] pct);
    logic [6:0] p;
    logic [22:0] prod;
    p = (pct > 7'(DFR_PCT_FULL)) ? 7'(DFR_PCT_FULL) : pct;
    prod = lim * p;
    return 16'(prod / 23'(DFR_PCT_FULL));
  endfunction : pct_of

  function automatic logic [7:0] first_idx(input logic [N_FUNC-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = N_FUNC - 1; i >= 0; i--) begin
      if (v[i]) r = 8'(i);
    end
    return r;
  endfunction : first_idx

  // ----------------------------------------------------------------
  // configuration registers and APB
  // ----------------------------------------------------------------
  logic overwrite_q, alarms_mode_q;
  logic [DFR_N_TRIG-1:0] trig_en_q;
  logic [15:0] limit_q;
  logic [6:0] pre_pct_q, post_pct_q;
  logic [31:0] mdelay_q;
  logic [RI_W-1:0] wsel_q;
  logic [PTR_W-1:0] maddr_q;
  logic [FI_W-1:0] fsel_q;
  logic manual_q;
  logic [31:0] prdata_q, rd_mux;
  logic rd_hit;

  wire acc = psel & penable;
  wire wr_acc = acc & pwrite;
  wire key_ok = pwdata[DFR_CMD_KEY_LO +: 16] == DFR_DELETE_KEY;
  wire cmd_wr = wr_acc & (paddr == DFR_OFS_CMD);
  wire del_sel = cmd_wr & pwdata[DFR_CMD_DEL_SEL] & key_ok; // [RULE13]
  wire del_all = cmd_wr & pwdata[DFR_CMD_DEL_ALL] & key_ok; // [RULE13]
  wire manual_set = cmd_wr & pwdata[DFR_CMD_MANUAL];
  wire [15:0] limit_wr = (pwdata[15:0] > 16'(DFR_LIMIT_MAX)) ? 16'(DFR_LIMIT_MAX)
                                                           : pwdata[15:0]; // [RULE5]

  assign pready = 1'b1;
  assign pslverr = acc & ~rd_hit;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overwrite_q <= DFR_CTRL_RST[DFR_CTRL_OVWR];
      alarms_mode_q <= DFR_CTRL_RST[DFR_CTRL_ALARMS];
      trig_en_q <= DFR_CTRL_RST[DFR_CTRL_TEN_LO +: DFR_N_TRIG];
      limit_q <= DFR_LIMIT_RST;
      pre_pct_q <= DFR_PRE_RST;
      post_pct_q <= DFR_POST_RST;
      mdelay_q <= DFR_MDELAY_RST;
      wsel_q <= '0;
      maddr_q <= '0;
      fsel_q <= '0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (psel & ~penable) prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      if (wr_acc) begin
        unique case (paddr)
          DFR_OFS_CTRL: begin
            overwrite_q <= pwdata[DFR_CTRL_OVWR];
            alarms_mode_q <= pwdata[DFR_CTRL_ALARMS];
            trig_en_q <= pwdata[DFR_CTRL_TEN_LO +: DFR_N_TRIG];
          end
          DFR_OFS_LIMIT: limit_q <= limit_wr;
          DFR_OFS_PCT: begin
            pre_pct_q <= pwdata[6:0];
            post_pct_q <= pwdata[DFR_PCT_POST_LO +: 7];
          end
          DFR_OFS_MDELAY: mdelay_q <= pwdata;
          DFR_OFS_WSEL: wsel_q <= pwdata[RI_W-1:0];
          DFR_OFS_MADDR: maddr_q <= pwdata[PTR_W-1:0];
          DFR_OFS_FSEL: fsel_q <= pwdata[FI_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sample grid
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  assign sample_tick = div_q == DIV_W'(SAMPLE_DIV_P - 1); // [RULE1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= '0;
    else div_q <= sample_tick ? '0 : div_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // waveform store and record table
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] mem [STORE_N];
  logic [SAMPLE_W-1:0] mem_rd_q;
  logic [PTR_W-1:0] tbl_start [MAX_RECS];
  logic [15:0] tbl_len [MAX_RECS];
  logic [31:0] tbl_fault [MAX_RECS];
  logic [MAX_RECS-1:0] tbl_valid_q;
  dfr_wstate_t wstate_q;
  logic [PTR_W-1:0] wr_q, rec_end_q;
  logic [PTR_W:0] hist_q;
  logic [RI_W-1:0] head_q, cur_q;
  logic [RI_W:0] cnt_q;
  logic [15:0] tot_q, post_cnt_q;
  logic [DFR_N_TRIG-1:0] cause_q;
  logic [15:0] fault_no_q, grid_no_q;

  wire [15:0] pre_capture_time = pct_of(limit_q, pre_pct_q); // [RULE6]
  wire [15:0] post_capture_time = pct_of(limit_q, post_pct_q); // [RULE6]
  wire [DFR_N_TRIG-1:0] trig_hit = trig_i & trig_en_q;
  wire lockout = |(trig_i & cause_q); // [RULE3]
  wire any_trig = |trig_hit | manual_q; // [RULE2] [RULE12]
  wire trigger_active = |(trig_i & cause_q); // [RULE8]
  wire [PTR_W-1:0] wr_nxt = ptr_add(wr_q, (PTR_W + 1)'(1));
  wire [PTR_W-1:0] tail = (cnt_q != '0) ? tbl_start[head_q] : wr_q;
  wire [PTR_W-1:0] start_ptr = ptr_add(wr_q, STORE_W - (PTR_W + 1)'(pre_capture_time));
  wire tbl_full = cnt_q == (RI_W + 1)'(MAX_RECS);
  wire hist_ok = hist_q >= (PTR_W + 1)'(pre_capture_time);
  wire [PTR_W-1:0] room_ptr = hist_ok ? start_ptr : rec_end_q;
  wire space_ok = (cnt_q == '0) | (ptr_dist(room_ptr, tail) > (PTR_W + 1)'(limit_q)); // [RULE4]
  wire store_full = ~overwrite_q & (tbl_full | ~space_ok); // [RULE11]
  wire idle = wstate_q == DFR_W_IDLE;
  wire start = sample_tick & idle & any_trig & ~lockout & ~store_full & hist_ok; // [RULE7]
  wire collide = sample_tick & (cnt_q != '0) & (wr_nxt == tail);
  wire drop = (collide & overwrite_q) | (start & tbl_full); // [RULE11]
  wire hist_wrap = collide & ~overwrite_q & idle;
  wire [RI_W-1:0] new_idx = head_q + cnt_q[RI_W-1:0];
  wire [15:0] tot_n = tot_q + 16'h0001;
  wire [15:0] post_n = post_cnt_q + 16'h0001;
  wire ev_end = sample_tick & (wstate_q == DFR_W_EVENT);
  wire limit_hit = tot_n >= limit_q; // [RULE10]
  wire finish = (ev_end & (limit_hit | (~trigger_active & (post_capture_time == '0))))
              | (sample_tick & (wstate_q == DFR_W_POST)
                 & (limit_hit | (post_n >= post_capture_time))); // [RULE9] [RULE10]
  wire [RI_W-1:0] wsel_idx = head_q + wsel_q;
  wire wsel_ok = ((RI_W + 1)'(wsel_q) < cnt_q) & tbl_valid_q[wsel_idx];

  assign wave_active = ~idle;

  always_ff @(posedge pclk) begin
    if (sample_tick & ~hist_wrap) mem[wr_q] <= sample_i; // [RULE25]
    mem_rd_q <= mem[maddr_q];
    if (start) begin
      tbl_start[new_idx] <= start_ptr;
      tbl_len[new_idx] <= pre_capture_time;
      tbl_fault[new_idx] <= {grid_no_q, fault_no_q}; // [RULE22]
    end
    if (finish) tbl_len[cur_q] <= tot_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_q <= 1'b0;
      cause_q <= '0;
    end else begin
      manual_q <= manual_set | (manual_q & ~start);
      if (start) cause_q <= trig_hit; // [RULE3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wstate_q <= DFR_W_IDLE;
      wr_q <= '0;
      rec_end_q <= '0;
      hist_q <= '0;
      head_q <= '0;
      cnt_q <= '0;
      cur_q <= '0;
      tot_q <= '0;
      post_cnt_q <= '0;
      tbl_valid_q <= '0;
    end else if (del_all) begin
      wstate_q <= DFR_W_IDLE;
      head_q <= '0;
      cnt_q <= '0;
      tbl_valid_q <= '0;
      rec_end_q <= wr_q;
    end else begin
      if (sample_tick) begin
        wr_q <= hist_wrap ? rec_end_q : wr_nxt; // [RULE25]
        hist_q <= hist_wrap ? '0 : ((hist_q == STORE_W) ? hist_q : hist_q + 1'b1);
      end
      if (drop) head_q <= head_q + 1'b1;
      cnt_q <= cnt_q + (RI_W + 1)'(start) - (RI_W + 1)'(drop);
      if (del_sel & ((RI_W + 1)'(wsel_q) < cnt_q)) tbl_valid_q[wsel_idx] <= 1'b0;
      if (start) begin
        tbl_valid_q[new_idx] <= 1'b1;
        cur_q <= new_idx;
        tot_q <= pre_capture_time; // [RULE7]
        wstate_q <= DFR_W_EVENT;
      end else if (finish) begin
        wstate_q <= DFR_W_IDLE;
        rec_end_q <= wr_nxt;
        hist_q <= '0;
      end else if (ev_end) begin
        tot_q <= tot_n;
        if (~trigger_active) begin
          wstate_q <= DFR_W_POST; // [RULE8]
          post_cnt_q <= '0;
        end
      end else if (sample_tick & (wstate_q == DFR_W_POST)) begin
        tot_q <= tot_n;
        post_cnt_q <= post_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // fault recorder
  // ----------------------------------------------------------------
  dfr_fault_rec_t fstore [FAULT_DEPTH_P];
  dfr_fault_rec_t cur_f;
  logic gp_q, f_active_q, meas_done_q, notify_q;
  logic [31:0] dly_q;
  logic [FI_W-1:0] fhead_q, fcnt_q, fsel_idx;

  wire gen_pickup = |pickup_i; // [RULE19]
  wire gen_trip = |trip_i; // [RULE20]
  wire gp_rise = gen_pickup & ~gp_q; // [RULE14]
  wire gp_fall = ~gen_pickup & gp_q & f_active_q;
  wire first_trip = f_active_q & ~cur_f.tripped & gen_trip;
  wire meas_due = cur_f.tripped & ~meas_done_q & (dly_q >= mdelay_q); // [RULE15]
  wire f_store = gp_fall & (cur_f.tripped | alarms_mode_q); // [RULE16]
  wire ffull = fcnt_q == FI_W'(FAULT_DEPTH_P);
  wire [FI_W:0] fw_sum = {1'b0, fhead_q} + {1'b0, fcnt_q};
  wire [FI_W-1:0] fw_idx = ffull ? fhead_q
                         : ((fw_sum >= (FI_W + 1)'(FAULT_DEPTH_P))
                            ? FI_W'(fw_sum - (FI_W + 1)'(FAULT_DEPTH_P)) : fw_sum[FI_W-1:0]);
  wire [FI_W-1:0] fh_nxt = (fhead_q == FI_W'(FAULT_DEPTH_P - 1)) ? '0 : fhead_q + 1'b1;
  wire [FI_W:0] fs_sum = {1'b0, fhead_q} + {1'b0, fsel_q};
  wire fsel_ok = fsel_q < fcnt_q;
  dfr_fault_rec_t fsel_rec;

  assign fsel_idx = (fs_sum >= (FI_W + 1)'(FAULT_DEPTH_P))
                  ? FI_W'(fs_sum - (FI_W + 1)'(FAULT_DEPTH_P)) : fs_sum[FI_W-1:0];
  assign fsel_rec = fstore[fsel_idx];
  assign fault_notify = notify_q;

  always_ff @(posedge pclk) begin
    if (f_store) fstore[fw_idx] <= cur_f; // [RULE24]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_q <= 1'b0;
      f_active_q <= 1'b0;
      meas_done_q <= 1'b0;
      notify_q <= 1'b0;
      dly_q <= '0;
      cur_f <= '0;
      fault_no_q <= '0;
      grid_no_q <= '0;
      fhead_q <= '0;
      fcnt_q <= '0;
    end else begin
      gp_q <= gen_pickup;
      notify_q <= gp_fall; // [RULE17]
      if (f_store) begin
        if (ffull) fhead_q <= fh_nxt; // [RULE24]
        else fcnt_q <= fcnt_q + 1'b1;
      end
      if (gp_rise) begin
        fault_no_q <= fault_no_q + 16'h0001; // [RULE23]
        grid_no_q <= grid_no_q + 16'h0001; // [RULE22]
        f_active_q <= 1'b1;
        meas_done_q <= 1'b0;
        dly_q <= '0;
        cur_f <= '0;
        cur_f.fault_no <= fault_no_q + 16'h0001;
        cur_f.grid_no <= grid_no_q + 16'h0001;
        cur_f.first_pu <= first_idx(pickup_i);
        if (gen_trip) begin
          cur_f.tripped <= 1'b1;
          cur_f.first_tr <= first_idx(trip_i);
          cur_f.ttt_valid <= first_idx(trip_i) == first_idx(pickup_i); // [RULE21]
        end
      end else if (f_active_q) begin
        if (gp_fall) f_active_q <= 1'b0;
        else cur_f.dur <= cur_f.dur + 32'h0000_0001; // [RULE19]
        if (~meas_done_q) cur_f.meas <= meas_i;
        if (~cur_f.tripped & ~gen_trip) cur_f.ttt <= cur_f.ttt + 32'h0000_0001; // [RULE18]
        if (first_trip) begin
          cur_f.tripped <= 1'b1;
          cur_f.first_tr <= first_idx(trip_i);
          cur_f.ttt_valid <= first_idx(trip_i) == cur_f.first_pu; // [RULE21]
        end
        if (cur_f.tripped & ~meas_done_q) dly_q <= dly_q + 32'h0000_0001;
        if (meas_due) begin
          cur_f.meas <= meas_i; // [RULE15]
          meas_done_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [31:0] status_w = {8'h00, 8'(fcnt_q), 8'(cnt_q), 5'h00, lockout, store_full, ~idle};

  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      DFR_OFS_CTRL: rd_mux = {16'h0000, trig_en_q, 6'h00, alarms_mode_q, overwrite_q};
      DFR_OFS_LIMIT: rd_mux = {16'h0000, limit_q};
      DFR_OFS_PCT: rd_mux = {17'h00000, post_pct_q, 1'b0, pre_pct_q};
      DFR_OFS_MDELAY: rd_mux = mdelay_q;
      DFR_OFS_CMD: rd_mux = 32'h0000_0000;
      DFR_OFS_STATUS: rd_mux = status_w;
      DFR_OFS_WSEL: rd_mux = 32'(wsel_q);
      DFR_OFS_WSTART: rd_mux = 32'(tbl_start[wsel_idx]);
      DFR_OFS_WLEN: rd_mux = {wsel_ok, 15'h0000, tbl_len[wsel_idx]};
      DFR_OFS_WFAULT: rd_mux = tbl_fault[wsel_idx];
      DFR_OFS_MADDR: rd_mux = 32'(maddr_q);
      DFR_OFS_MDATA: rd_mux = 32'(mem_rd_q);
      DFR_OFS_FSEL: rd_mux = 32'(fsel_q);
      DFR_OFS_FNUM: rd_mux = {fsel_rec.grid_no, fsel_rec.fault_no};
      DFR_OFS_FTTT: rd_mux = {fsel_rec.ttt_valid, fsel_rec.ttt[30:0]};
      DFR_OFS_FDUR: rd_mux = fsel_rec.dur;
      DFR_OFS_FMEAS: rd_mux = fsel_rec.meas;
      DFR_OFS_FINFO: rd_mux = {fsel_ok, 14'h0000, fsel_rec.tripped,
                               fsel_rec.first_tr, fsel_rec.first_pu};
      default: begin
        rd_hit = 1'b0;
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

endmodule : dfr_recorder

// [dv/dfr_recorder_props.sv]
`timescale 1ns/1ps
module dfr_recorder_props import dfr_pkg::*; #(
  parameter int SAMPLE_DIV_P = 4,
  parameter int N_FUNC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [DFR_N_TRIG-1:0] trig_i,
  input wire logic [N_FUNC-1:0] pickup_i,
  input wire logic sample_tick,
  input wire logic wave_active,
  input wire logic fault_notify
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [31:0] cnt_q;
  logic seen_q;
  logic man_q;
  logic lock_q;
  logic [7:0] cause_q;
  wire man_wr = psel && penable && pwrite && paddr == DFR_OFS_CMD && pwdata[DFR_CMD_MANUAL];
  wire held = |(trig_i & cause_q);
  // ----------------------------------------------------------------
  // tick spacing, manual request and lockout trackers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
      man_q <= 1'b0;
      lock_q <= 1'b0;
      cause_q <= '0;
    end else begin
      cnt_q <= sample_tick ? 32'h0 : cnt_q + 32'h1;
      seen_q <= seen_q | sample_tick;
      man_q <= man_wr | (man_q & ~$rose(wave_active));
      if ($rose(wave_active)) cause_q <= $past(trig_i);
      lock_q <= held & ($fell(wave_active) | lock_q);
    end
  end
  AST_TICK_PERIOD: assert property (sample_tick && seen_q |-> cnt_q == SAMPLE_DIV_P - 1)
    else $error("sample tick spacing wrong");
  AST_TICK_PULSE: assert property (sample_tick |=> !sample_tick)
    else $error("sample tick longer than one cycle");
  AST_WAVE_ON_TICK: assert property ($rose(wave_active) |-> $past(sample_tick))
    else $error("record started off the sample grid");
  AST_WAVE_STOP_TICK: assert property ($fell(wave_active) |-> $past(sample_tick))
    else $error("record stopped off the sample grid");
  AST_START_CAUSE: assert property ($rose(wave_active) |-> $past(|trig_i) || man_q)
    else $error("record started without trigger");
  AST_LOCKOUT: assert property (lock_q |-> !$rose(wave_active))
    else $error("record started while causing trigger held");
  AST_NOTIFY_ON_FALL: assert property ($fell(|pickup_i) && $past(presetn) |=> fault_notify)
    else $error("no notify after pickup fall");
  AST_NOTIFY_CAUSE: assert property (fault_notify |-> !$past(|pickup_i) && $past(|pickup_i, 2))
    else $error("notify without pickup fall");
endmodule : dfr_recorder_props
bind dfr_recorder dfr_recorder_props #(.SAMPLE_DIV_P(SAMPLE_DIV_P), .N_FUNC(N_FUNC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .trig_i(trig_i), .pickup_i(pickup_i),
  .sample_tick(sample_tick), .wave_active(wave_active), .fault_notify(fault_notify));

// [dv/dfr_prot_model.sv]
`timescale 1ns/1ps
module dfr_prot_model (
  input wire logic pclk,
  output logic [7:0] pickup_i,
  output logic [7:0] trip_i
);
  initial begin
    pickup_i = '0;
    trip_i = '0;
  end
  // function pu picks up; if tp, after dly, tr picks up and trips
  task automatic fault(input int pu, input int tr, input int dly, input int dur, input logic tp);
    int i;
    @(posedge pclk);
    pickup_i[pu] <= 1'b1;
    for (i = 1; i < dur; i++) begin
      @(posedge pclk);
      if (tp && i == dly) begin
        pickup_i[tr] <= 1'b1;
        trip_i[tr] <= 1'b1;
      end
    end
    @(posedge pclk);
    pickup_i <= '0;
    trip_i <= '0;
  endtask : fault
endmodule : dfr_prot_model

// [dv/dfr_recorder_bench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module dfr_recorder_bench import dfr_pkg::*;;
  localparam int LIM = 40;
  localparam int PRE = LIM * 25 / 100;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic sample_tick, wave_active, fault_notify, m, j;
  logic [7:0] paddr, trig_i, pickup_i, trip_i, c;
  logic [15:0] fno;
  logic [31:0] pwdata, prdata, sample_i, meas_i, q, mv;
  int seed, mismatches, compares, k, t, pu, tr;
  dfr_recorder #(.SAMPLE_DIV_P(4), .STORE_N(256)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_i(sample_i),
    .trig_i(trig_i), .pickup_i(pickup_i), .trip_i(trip_i), .meas_i(meas_i),
    .sample_tick(sample_tick), .wave_active(wave_active), .fault_notify(fault_notify));
  dfr_prot_model prot (.pclk(pclk), .pickup_i(pickup_i), .trip_i(trip_i));
  always #2 pclk = ~pclk;
  always @(posedge pclk) sample_i <= $random(seed);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // newest record of the wave (f=0) or fault (f=1) store
  task automatic rec(input logic f, input logic [7:0] a);
    apb(1'b0, DFR_OFS_STATUS, 32'h0);
    apb(1'b1, f ? DFR_OFS_FSEL : DFR_OFS_WSEL, {24'h0, (f ? q[23:16] : q[15:8]) - 8'h1});
    apb(1'b0, a, 32'h0);
  endtask : rec
  task automatic ww(input logic v);
    int n;
    for (n = 0; n < 3000 && wave_active !== v; n++) @(posedge pclk);
    `CHK(wave_active, v)
  endtask : ww
  function automatic int exp_len(input int tt);
    int ev = tt < LIM - PRE ? tt : LIM - PRE;
    int po = PRE < LIM - PRE - ev ? PRE : LIM - PRE - ev;
    return PRE + ev + po;
  endfunction : exp_len
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    mismatches++;
    $display("ERROR %0t timeout", $time);
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, trig_i, meas_i, fno} = '0;
    seed = 3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DFR_OFS_CTRL, 32'h0);
    `CHK(q, DFR_CTRL_RST)
    apb(1'b0, DFR_OFS_PCT, 32'h0);
    `CHK(q[14:0], {DFR_POST_RST, 1'b0, DFR_PRE_RST})
    apb(1'b0, 8'hF0, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, DFR_OFS_LIMIT, 32'hFFFF);
    apb(1'b0, DFR_OFS_LIMIT, 32'h0);
    `CHK(q[15:0], 16'h5DC0)
    apb(1'b1, DFR_OFS_LIMIT, LIM);
    apb(1'b1, DFR_OFS_PCT, 32'h1919);
    $display("test registers done");
    for (k = 0; k < 3; k++) begin
      t = k == 0 ? 60 : ($random(seed) & 3) + 1;
      repeat (60) @(posedge pclk);
      trig_i <= 8'h1 << k;
      ww(1'b1);
      repeat (t * 4) @(posedge pclk);
      if (t > LIM) begin
        apb(1'b0, DFR_OFS_STATUS, 32'h0);
        `CHK(q[2] & ~wave_active, 1'b1)
      end
      trig_i <= 8'h0;
      ww(1'b0);
      rec(1'b0, DFR_OFS_WLEN);
      `CHK(q[15:0] + 1 >= exp_len(t) && q[15:0] <= exp_len(t) + 1 && q[15:0] <= LIM, 1'b1)
    end
    $display("test waveform lengths done");
    for (k = 0; k < 4; k++) begin
      m = k[1];
      j = k[0];
      apb(1'b1, DFR_OFS_CTRL, m ? 32'hFF03 : 32'hFF01);
      apb(1'b0, DFR_OFS_STATUS, 32'h0);
      c = q[23:16];
      pu = $random(seed) & 7;
      tr = m ? pu : pu ^ 1;
      mv = $random(seed);
      meas_i <= mv;
      prot.fault(pu, tr, 20, 50, j);
      fno++;
      repeat (4) @(posedge pclk);
      apb(1'b0, DFR_OFS_STATUS, 32'h0);
      `CHK(q[23:16], c + (j | m))
      if (j | m) begin
        rec(1'b1, DFR_OFS_FNUM);
        `CHK(q, {fno, fno})
        rec(1'b1, DFR_OFS_FDUR);
        `CHK(q >= 48 && q <= 52, 1'b1)
        rec(1'b1, DFR_OFS_FMEAS);
        `CHK(q, mv)
        rec(1'b1, DFR_OFS_FINFO);
        `CHK(q[7:0], 8'(pu))
      end
      if (j) begin
        `CHK(q[15:8], 8'(tr))
        rec(1'b1, DFR_OFS_FTTT);
        `CHK(q[31], m)
        `CHK((q[30:0] >= 18 && q[30:0] <= 22) || !m, 1'b1)
      end
    end
    $display("test fault records done");
    apb(1'b1, DFR_OFS_CMD, 32'h1);
    ww(1'b1);
    ww(1'b0);
    rec(1'b0, DFR_OFS_WFAULT);
    `CHK(q, {fno, fno})
    apb(1'b1, DFR_OFS_CMD, 32'h4);
    apb(1'b0, DFR_OFS_STATUS, 32'h0);
    `CHK(q[15:8] != 8'h0, 1'b1)
    apb(1'b1, DFR_OFS_CMD, {DFR_DELETE_KEY, 16'h4});
    apb(1'b0, DFR_OFS_STATUS, 32'h0);
    `CHK(q[15:8], 8'h0)
    apb(1'b1, DFR_OFS_CTRL, 32'hFF00);
    for (k = 0; k < 30 && q[1] !== 1'b1; k++) begin
      apb(1'b1, DFR_OFS_CMD, 32'h1);
      ww(1'b1);
      ww(1'b0);
      apb(1'b0, DFR_OFS_STATUS, 32'h0);
    end
    `CHK(q[1], 1'b1)
    apb(1'b1, DFR_OFS_CMD, 32'h1);
    repeat (200) @(posedge pclk);
    `CHK(wave_active, 1'b0)
    apb(1'b1, DFR_OFS_CTRL, 32'hFF01);
    ww(1'b1);
    ww(1'b0);
    $display("test manual, delete and overwrite done");
    tally_and_finish;
  end
endmodule : dfr_recorder_bench
